// [dv/adsr_link_monitor.sv]
/* Concurrent checks on the link between the host and converter ends.
   Assumes it watches the one interface that joins the two design ends. */
`timescale 1ns/1ps
`default_nettype none
module adsr_link_monitor (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    logic [4:0] rise_cnt_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Counts clock rises inside one selection, saturating for two-wire use.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rise_cnt_ff <= 5'h00;
        end else if (cs_n) begin
            rise_cnt_ff <= 5'h00;
        end else if ($rose(sck) && rise_cnt_ff != 5'h1F) begin
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
        end
    end
    a_release_idle: assert property (cs_n [*4] |-> !sdo_oe)
        else $error("data pin driven while deselected");
    a_drive_selected: assert property (!cs_n [*4] |-> sdo_oe)
        else $error("data pin released while selected");
    a_abort_release: assert property ($rose(cs_n) |-> ##[1:4] !sdo_oe)
        else $error("data pin not released after deselect");
    a_hold_on_rise: assert property ($rose(sck) && !cs_n |=> $stable(sdo_o) [*4])
        else $error("data changed around sampling edge");
    a_quiet_select: assert property ($fell(cs_n) |=> $stable(sck) [*8])
        else $error("clock moved right after select");
    a_half_period: assert property ($changed(sck) && !cs_n |=> $stable(sck) [*8])
        else $error("clock half period too short");
    a_edge_count: assert property ($rose(cs_n) |-> rise_cnt_ff inside {5'h10, 5'h11})
        else $error("deselect after wrong number of clock pulses");
    a_deselect_hold: assert property ($rose(cs_n) |=> cs_n [*8])
        else $error("reselected too soon after a read");
    c_plain_read: cover property ($rose(cs_n) && rise_cnt_ff == 5'h10);
    c_extra_pulse: cover property ($rose(cs_n) && rise_cnt_ff == 5'h11);
    c_status_low: cover property (!cs_n && sck && $fell(sdo_o));
endmodule
`default_nettype wire

// [dv/tb.sv]
/* Self-checking bench: host and converter ends joined, plus a second converter.
   Assumes the second converter's link is driven directly by this bench. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adsr_pkg::*;
    logic clk_sys, reset_n, cpol, two_wire, use_extra, start;
    logic busy, data_valid, done_a, done_b;
    logic signed [16:0] samp_a, samp_b;
    logic [15:0] data, v;
    adsr_state_t st_a, st_b;
    int n_errors = 0;
    int total_checks = 0;
    adsr_if u_link();
    adsr_if u_tb_link();
    adsr_device #(.CONV_CYC(200)) u_adsr_device (.clk_sys(clk_sys), .reset_n(reset_n),
        .link(u_link), .sample_in(samp_a), .conv_done(done_a), .state(st_a));
    adsr_device #(.CONV_CYC(200)) u_adsr_device_b (.clk_sys(clk_sys), .reset_n(reset_n),
        .link(u_tb_link), .sample_in(samp_b), .conv_done(done_b), .state(st_b));
    adsr_host #(.WAIT_CYC(260), .HALF_CYC(16)) u_adsr_host (.clk_sys(clk_sys),
        .reset_n(reset_n), .link(u_link), .cpol(cpol), .two_wire(two_wire),
        .use_extra_pulse(use_extra), .start(start), .busy(busy), .data(data),
        .data_valid(data_valid));
    adsr_link_monitor u_adsr_link_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
        .sck(u_link.sck), .cs_n(u_link.cs_n), .sdo_o(u_link.sdo_o), .sdo_oe(u_link.sdo_oe));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors=%0d checks=%0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Drives one half period of the bench-made link clock, 85 ns.
    task automatic lk(input logic s, input logic c);
        @(posedge clk_sys);
        #1;
        u_tb_link.sck = s;
        u_tb_link.cs_n = c;
        repeat (16) @(posedge clk_sys);
        #1;
    endtask
    // Waits for conv_done of the second converter or for data_valid of the host.
    task automatic wait_hi(input logic host);
        for (int i = 0; i < 1000; i++) begin
            @(negedge clk_sys);
            if ((host ? data_valid : done_b) === 1'b1) begin
                return;
            end
        end
        n_errors++;
        complete_run();
    endtask
    task automatic read_b(input int n);
        v = 16'h0000;
        lk(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            lk(1'b1, 1'b0);
            v = {v[14:0], u_tb_link.sdo};
            lk(1'b0, 1'b0);
        end
    endtask
    task automatic host_read(input logic p, input logic tw, input logic ex,
                             input logic signed [16:0] s, input logic [15:0] exp);
        @(posedge clk_sys);
        #1;
        cpol = p;
        two_wire = tw;
        use_extra = ex;
        samp_a = s;
        start = 1'b1;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        chk(16'(busy), 16'h0001);
        wait_hi(1'b1);
        chk(data, exp);
    endtask
    initial begin
        reset_n = 1'b0;
        cpol = 1'b1;
        two_wire = 1'b0;
        use_extra = 1'b0;
        start = 1'b0;
        samp_a = 17'sd0;
        samp_b = -17'sd5;
        u_tb_link.sck = 1'b1;
        u_tb_link.cs_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        lk(1'b1, 1'b0);
        chk(16'(u_tb_link.sdo), 16'h0001);
        chk(16'(u_tb_link.sdo_oe), 16'h0001);
        wait_hi(1'b0);
        lk(1'b1, 1'b0);
        chk(16'(u_tb_link.sdo), 16'h0000);
        chk(16'(st_b), 16'(ADSR_SLEEP));
        lk(1'b0, 1'b0);
        chk(16'(u_tb_link.sdo), 16'h0000);
        chk(16'(st_b), 16'(ADSR_OUTPUT));
        samp_b = 17'sd16384;
        lk(1'b0, 1'b1);
        chk(16'(st_b), 16'(ADSR_CONVERT));
        chk(16'(u_tb_link.sdo_oe), 16'h0000);
        repeat (3) begin
            lk(1'b1, 1'b0);
            lk(1'b0, 1'b0);
        end
        chk(16'(st_b), 16'(ADSR_CONVERT));
        lk(1'b0, 1'b1);
        wait_hi(1'b0);
        read_b(8);
        chk(v, 16'h00C0);
        samp_b = -17'sd40000;
        lk(1'b0, 1'b1);
        chk(16'(st_b), 16'(ADSR_CONVERT));
        wait_hi(1'b0);
        read_b(16);
        chk(v, 16'h0000);
        chk(16'(st_b), 16'(ADSR_CONVERT));
        lk(1'b0, 1'b1);
        host_read(1'b1, 1'b0, 1'b0, 17'sd0, 16'h8000);
        host_read(1'b1, 1'b0, 1'b1, 17'sd32767, 16'hFFFF);
        host_read(1'b0, 1'b0, 1'b0, -17'sd1, 16'h7FFF);
        host_read(1'b1, 1'b1, 1'b1, -17'sd32768, 16'h0000);
        host_read(1'b0, 1'b1, 1'b0, 17'sd40000, 16'hFFFF);
        complete_run();
    end
endmodule
`default_nettype wire

// [rtl/adsr_device.sv]
/*
 * Converter end: conversion timer, sleep, and serial result output.
 * Assumes the host drives clock and chip select asynchronously to clk_sys.
 */
// Operation
// - Clock high, select low: data shows busy
// - Conversion takes a fixed nominal time
// - Works with either clock idle level
// - After sixteen bits, select rise or next clock fall restarts
// - Select rise during output aborts and restarts
// - Status polling only with clock idling high
// - Seventeenth falling edge restarts with idle-high clock
// - Idle-low: sixteenth falling edge restarts
// - Clock low: select pulse gives sign, restarts
// - Clock pulses during conversion change nothing
// - Two-wire host ties select low
// - Two-wire idle-high: sleep, data low, then read
// - Two-wire idle-low: skip sleep, present sign
// - Two-wire host checks data levels, forces restart; host here uses its timer, restarts idle-high only with use_extra_pulse
// - Next bit after each falling edge, MSB first
// - Sleep holds result until select and clock low
// - Offset binary result clamped to code limits
`timescale 1ns/1ps
`default_nettype none
module adsr_device #(
    parameter int unsigned CONV_CYC = adsr_pkg::CONV_NOM_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    adsr_if.dev link,
    input wire logic signed [16:0] sample_in,
    output logic conv_done,
    output var adsr_pkg::adsr_state_t state
);
    import adsr_pkg::*;

    logic [1:0] sck_sync_ff;
    logic [1:0] cs_sync_ff;
    logic sck_d_ff;
    logic cs_d_ff;
    logic [31:0] conv_cnt_ff;
    logic [15:0] result_ff;
    logic [15:0] shift_ff;
    logic [4:0] fall_cnt_ff;
    logic sdo_ff;
    adsr_state_t state_ff;
    adsr_state_t nxt_state;
    logic sck;
    logic cs_n;
    logic sck_fall;
    logic cs_rise;
    logic conv_end;
    logic restart;

    // Clamp a signed offset-binary sum to the 16-bit code range.
    function automatic logic [15:0] clamp_code(input logic signed [16:0] v);
        logic signed [17:0] s;
        s = 18'(v) + 18'sd32768;
        if (s > 18'sd65535) begin
            return RESULT_MAX;
        end else if (s < 18'sd0) begin
            return RESULT_MIN;
        end
        return s[15:0];
    endfunction

    assign sck = sck_sync_ff[1];
    assign cs_n = cs_sync_ff[1];
    assign sck_fall = sck_d_ff & ~sck;
    assign cs_rise = ~cs_d_ff & cs_n;
    assign conv_end = (state_ff == ADSR_CONVERT) && (conv_cnt_ff == CONV_CYC - 1);
    // Restart on select rise at any point during output (abort), or on the falling edge after all bits.
    assign restart = cs_rise || (sck_fall && fall_cnt_ff == 5'(RESULT_BITS - 1));

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sck_sync_ff <= 2'h0;
            cs_sync_ff <= 2'h3;
            sck_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
        end else begin
            sck_sync_ff <= {sck_sync_ff[0], link.sck};
            cs_sync_ff <= {cs_sync_ff[0], link.cs_n};
            sck_d_ff <= sck;
            cs_d_ff <= cs_n;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ADSR_CONVERT: begin
                // Clock edges here are ignored; only the timer ends it.
                if (conv_end) begin
                    nxt_state = ADSR_SLEEP;
                end
            end
            ADSR_SLEEP: begin
                // Select low with clock low also covers two-wire idle-low skipping sleep.
                if (!cs_n && !sck) begin
                    nxt_state = ADSR_OUTPUT;
                end
            end
            ADSR_OUTPUT: begin
                if (restart) begin
                    nxt_state = ADSR_CONVERT;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ADSR_CONVERT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            conv_cnt_ff <= 32'h0;
            result_ff <= RESULT_RESET;
        end else if (state_ff != ADSR_CONVERT) begin
            conv_cnt_ff <= 32'h0;
        end else if (conv_end) begin
            conv_cnt_ff <= 32'h0;
            result_ff <= clamp_code(sample_in);
        end else begin
            conv_cnt_ff <= conv_cnt_ff + 32'h1;
        end
    end

    // Each falling edge in output that does not restart shifts the next bit out, MSB first.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_ff <= 16'h0;
            fall_cnt_ff <= 5'h0;
        end else if (state_ff != ADSR_OUTPUT) begin
            shift_ff <= result_ff;
            fall_cnt_ff <= 5'h0;
        end else if (sck_fall && !restart) begin
            shift_ff <= {shift_ff[14:0], 1'b0};
            fall_cnt_ff <= fall_cnt_ff + 5'h1;
        end
    end

    // Status shows high while converting, low in sleep; output shows the current bit.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sdo_ff <= 1'b1;
        end else begin
            unique case (nxt_state)
                ADSR_CONVERT: sdo_ff <= 1'b1;
                ADSR_SLEEP: sdo_ff <= 1'b0;
                ADSR_OUTPUT: begin
                    if (state_ff != ADSR_OUTPUT) begin
                        sdo_ff <= result_ff[15];
                    end else if (sck_fall) begin
                        sdo_ff <= shift_ff[14];
                    end
                end
            endcase
        end
    end

    assign link.sdo_o = sdo_ff;
    assign link.sdo_oe = ~cs_n;
    assign conv_done = conv_end;
    assign state = state_ff;
endmodule
`default_nettype wire

// [rtl/adsr_host.sv]
/*
 * Host end: waits for a conversion, then clocks out sixteen bits.
 * Assumes the converter behaves as the device end of the link.
 */
`timescale 1ns/1ps
`default_nettype none
module adsr_host #(
    parameter int unsigned WAIT_CYC = adsr_pkg::CONV_MAX_CYC,
    parameter int unsigned HALF_CYC = adsr_pkg::SCK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    adsr_if.host link,
    input wire logic cpol,
    input wire logic two_wire,
    input wire logic use_extra_pulse,
    input wire logic start,
    output logic busy,
    output logic [15:0] data,
    output logic data_valid
);
    import adsr_pkg::*;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_WAIT,
        HST_SELECT,
        HST_SHIFT,
        HST_FINISH
    } adsr_host_state_t;

    adsr_host_state_t st_ff;
    logic [1:0] sdo_sync_ff;
    logic [31:0] wait_ff;
    logic [7:0] div_ff;
    logic [5:0] edge_ff;
    logic sck_ff;
    logic cs_n_ff;
    logic [15:0] data_ff;
    logic valid_ff;
    logic tick;
    logic [5:0] last_edge;

    assign tick = (div_ff == 8'(HALF_CYC - 1));
    // Idle-high with extra pulse needs 34 half-periods; otherwise 32.
    assign last_edge = (cpol && use_extra_pulse) ? 6'h22 : 6'h20;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sdo_sync_ff <= 2'h3;
        end else begin
            sdo_sync_ff <= {sdo_sync_ff[0], link.sdo};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= 8'h0;
        end else if (tick || st_ff == HST_IDLE) begin
            div_ff <= 8'h0;
        end else begin
            div_ff <= div_ff + 8'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= HST_IDLE;
            wait_ff <= 32'h0;
            edge_ff <= 6'h0;
            sck_ff <= 1'b1;
            cs_n_ff <= 1'b1;
            data_ff <= 16'h0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            unique case (st_ff)
                HST_IDLE: begin
                    sck_ff <= cpol;
                    cs_n_ff <= ~two_wire;
                    if (start) begin
                        st_ff <= HST_WAIT;
                        wait_ff <= 32'h0;
                    end
                end
                HST_WAIT: begin
                    // Own timer decides readiness; idle-low polling is never used.
                    wait_ff <= wait_ff + 32'h1;
                    if (wait_ff >= WAIT_CYC - 1) begin
                        st_ff <= HST_SELECT;
                    end
                end
                HST_SELECT: begin
                    cs_n_ff <= 1'b0;
                    if (tick) begin
                        st_ff <= HST_SHIFT;
                        edge_ff <= 6'h0;
                    end
                end
                HST_SHIFT: begin
                    if (tick) begin
                        sck_ff <= ~sck_ff;
                        edge_ff <= edge_ff + 6'h1;
                        // Sample on rising edges, which come before the next falling one.
                        if (!sck_ff && edge_ff < 6'h20) begin
                            data_ff <= {data_ff[14:0], sdo_sync_ff[1]};
                        end
                        if (edge_ff == last_edge - 6'h1) begin
                            st_ff <= HST_FINISH;
                        end
                    end
                end
                HST_FINISH: begin
                    if (tick) begin
                        cs_n_ff <= ~two_wire;
                        sck_ff <= cpol;
                        valid_ff <= 1'b1;
                        st_ff <= HST_IDLE;
                    end
                end
                default: st_ff <= HST_IDLE;
            endcase
        end
    end

    assign link.sck = sck_ff;
    assign link.cs_n = cs_n_ff;
    assign busy = (st_ff != HST_IDLE);
    assign data = data_ff;
    assign data_valid = valid_ff;
endmodule
`default_nettype wire

// [rtl/adsr_if.sv]
/*
 * Three-wire link between the converter and its host.
 * Resolves the data pin from its output enable, reading high when released.
 */
`timescale 1ns/1ps
`default_nettype none
interface adsr_if;
    logic sck;
    logic cs_n;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;
    assign sdo = sdo_oe ? sdo_o : 1'b1;
    modport dev (input sck, input cs_n, output sdo_o, output sdo_oe);
    modport host (output sck, output cs_n, input sdo);
endinterface
`default_nettype wire

// [rtl/adsr_pkg.sv]
/*
 * Shared constants for the serial readout of a 16-bit converter.
 * Assumes a 200 MHz system clock on both ends.
 */
package adsr_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned RESULT_BITS = 16;
    localparam int unsigned CONV_NOM_US = 16600;
    localparam int unsigned CONV_MAX_US = 23000;
    localparam int unsigned CONV_NOM_CYC = CONV_NOM_US * CLK_MHZ;
    localparam int unsigned CONV_MAX_CYC = CONV_MAX_US * CLK_MHZ;
    localparam int unsigned SCK_HALF_CYC = 16;
    localparam logic [15:0] RESULT_RESET = 16'h8000;
    localparam logic [15:0] RESULT_MAX = 16'hFFFF;
    localparam logic [15:0] RESULT_MIN = 16'h0000;
    typedef enum logic [1:0] {
        ADSR_CONVERT,
        ADSR_SLEEP,
        ADSR_OUTPUT
    } adsr_state_t;
endpackage
